// [slom_pkg.sv]
package slom_pkg;
  // Register indices; byte address is four times the index
  localparam logic [7:0] IDX_PM_LOAD  = 8'h05;
  localparam logic [7:0] IDX_SEC_CTL  = 8'h10;
  localparam logic [7:0] IDX_SEC_STAT = 8'h11;
  localparam logic [7:0] IDX_CNT_LO   = 8'h12;
  localparam logic [7:0] IDX_CNT_HI   = 8'h13;
  localparam logic [7:0] IDX_TX_CTL   = 8'h14;
  localparam logic [7:0] IDX_TX_DIAG  = 8'h15;
  localparam logic [7:0] IDX_LINE_CTL = 8'h18;
  localparam logic [7:0] IDX_NONE     = 8'hFF;
  // Writable bits of each control register
  localparam logic [7:0] SEC_CTL_MASK  = 8'h8F;
  localparam logic [7:0] TX_CTL_MASK   = 8'h7F;
  localparam logic [7:0] TX_DIAG_MASK  = 8'h07;
  localparam logic [7:0] LINE_CTL_MASK = 8'hFC;
  localparam logic [7:0] REG_RST       = 8'h00;
  // Flag vector positions, status byte is {0, flags, states}
  localparam int FL_OOF = 0;
  localparam int FL_LOF = 1;
  localparam int FL_LOS = 2;
  localparam int FL_PAR = 3;
  localparam logic [3:0] FLAGS_ALL = 4'hF;
  // Section control bits
  localparam int SC_PAR_EN = 3;
  localparam int SC_B1_WORD = 7;
  // Transmit control and diagnostic bits
  localparam int TC_LINE_ALARM_INSERT = 0;
  localparam int TC_BYPASS = 6;
  localparam int TD_A1 = 0;
  localparam int TD_B1 = 1;
  localparam int TD_ZERO = 2;
  // Receive line control bits
  localparam int LC_FEBE_WORD = 2;
  localparam int LC_IND_WORD  = 3;
  localparam int LC_RDI_SEL   = 4;
  localparam int LC_AIS_SEL   = 5;
  localparam int LC_ONES      = 6;
  localparam int LC_B2_WORD   = 7;
  // Line codes and patterns
  localparam logic [2:0] K2_RDI       = 3'h6;
  localparam logic [2:0] K2_AIS       = 3'h7;
  localparam logic [2:0] PERSIST_FAST = 3'h3;
  localparam logic [2:0] PERSIST_SLOW = 3'h5;
  localparam logic [4:0] MAX_ERR      = 5'h18;
  localparam logic [7:0] A1_ERR       = 8'h76;
  localparam logic [7:0] BYTE_ONES    = 8'hFF;
  localparam logic [7:0] BYTE_ZERO    = 8'h00;
  localparam logic [6:0] SCR_SEED     = 7'h7F;
  localparam logic [15:0] CNT_MAX     = 16'hFFFF;
  // Poll transfer deadline
  localparam int CLK_NS  = 40;
  localparam int POLL_NS = 7000;
  localparam int POLL_CYC = POLL_NS / CLK_NS;

  typedef struct packed {
    logic [7:0] data;
    logic       frame_start;
    logic       soh;
    logic       row1;
    logic       a1;
    logic       b1;
  } slom_tx_in_t;

  typedef struct packed {
    logic [7:0] data;
    logic       oof;
    logic       lof;
    logic       los;
    logic       b1_valid;
    logic [3:0] b1_errs;
    logic       frame_done;
    logic [2:0] k2;
    logic [4:0] b2_errs;
    logic [4:0] m1_errs;
  } slom_rx_in_t;

  typedef struct packed {
    logic [4:0] b2_count;
    logic [4:0] febe_count;
    logic [4:0] b2_indicate;
  } slom_evt_t;

  typedef struct packed {
    logic       dp_wr;
    logic       rd_wait;
    logic [7:0] idx;
    logic [7:0] rdata;
    logic [7:0] sec_ctl;
    logic [7:0] tx_ctl;
    logic [7:0] tx_diag;
    logic [7:0] line_ctl;
    logic [2:0] prev;
    logic [3:0] flags;
    logic [15:0] acc;
    logic [15:0] cnt;
    logic       perf_load;
    logic       irq;
    logic [2:0] rdi_cnt;
    logic [2:0] ais_cnt;
    logic       rdi_st;
    logic       ais_st;
    slom_evt_t  evt;
    logic       ais_act;
    logic [6:0] scr;
    logic [7:0] tx_out;
    logic [7:0] rx_out;
  } slom_st_t;

  localparam slom_st_t ST_RST = '0;
endpackage

// [slom_top.sv]
// Behaviour
// - Live out-of-frame, frame loss, signal loss states
// - Alarm change flags, cleared by status read
// - Section parity flag on B1 error
// - Readable 16-bit B1 error count
// - Count write copies accumulator, restarts it
// - Coincident error lands in the copy, not the accumulator
// - Global load write also polls, pulses load
// - Line AIS insertion changes at frame boundary
// - AIS forces non-overhead bits to one
// - Scrambler bypass bit sends stream unscrambled
// - Framing inject sends A1 as 0x76
// - Parity inject inverts every B1 byte
// - Forced signal loss sends all-zero bytes
// - Live line RDI and AIS states
// - FEBE count per frame or per bit
// - B2 indication per frame or per bit
// - Indication mode independent of count mode
// - RDI after 3 or 5 frames of 110
// - AIS after 3 or 5 frames of 111
// - Forced all-ones downstream during line AIS
// - B2 count per frame or per bit
// - Enabled alarm changes raise interrupt
//
// Our own choice: register access over AHB-Lite.
`timescale 1ns/1ps
module slom_top
  import slom_pkg::*;
(
  // Clock and reset
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // AHB-Lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic        hready,
  input  wire logic [31:0] hwdata,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  // Receive side
  input  wire slom_rx_in_t rx_in,
  output logic      [7:0]  rx_byte_out,
  output slom_evt_t        evt_out,
  output logic             alarm_irq,
  output logic             perf_load,
  // Transmit side
  input  wire slom_tx_in_t tx_in,
  output logic      [7:0]  tx_byte_out
);

  localparam int POLL_LIM = POLL_CYC;

  slom_st_t    st_r;
  slom_st_t    st_nxt;
  logic        accept;
  logic        wr;
  logic        poll;
  logic        rd_clr;
  logic [2:0]  alarms;
  logic [3:0]  flag_set;
  logic [4:0]  b1_inc;
  logic [15:0] exp_sum;
  logic [2:0]  rdi_new;
  logic [2:0]  ais_new;
  logic        ais_now;
  logic [14:0] scr_res;
  logic [7:0]  txb;

  // Saturating add keeps a flooded counter pinned, not wrapped
  function automatic logic [15:0] sat_add(input logic [15:0] a,
                                          input logic [4:0]  i);
    logic [16:0] s;
    s = {1'b0, a} + {12'h000, i};
    return s[16] ? CNT_MAX : s[15:0];
  endfunction

  // Per-frame event count, or one per errored frame in word mode
  function automatic logic [4:0] err_cnt(input logic [4:0] e,
                                         input logic       word);
    logic [4:0] c;
    c = (e > MAX_ERR) ? MAX_ERR : e;
    if (word) begin
      c = (e != 5'h00) ? 5'h01 : 5'h00;
    end
    return c;
  endfunction

  // Consecutive-frame run length, capped at the slow limit
  function automatic logic [2:0] persist(input logic [2:0] c,
                                         input logic       hit);
    logic [2:0] r;
    r = 3'h0;
    if (hit) begin
      r = (c >= PERSIST_SLOW) ? c : c + 3'h1;
    end
    return r;
  endfunction

  // One byte of the x^7+x^6+1 frame-synchronous scrambler
  function automatic logic [14:0] scr_step(input logic [6:0] s);
    logic [6:0] v;
    logic [7:0] k;
    v = s;
    k = BYTE_ZERO;
    for (int i = 7; i >= 0; i--) begin
      k[i] = v[6];
      v = {v[5:0], v[6] ^ v[5]};
    end
    return {v, k};
  endfunction

  // Next state of bus, registers, alarms and both streams
  always_comb begin
    st_nxt = st_r;
    alarms = {rx_in.los, rx_in.lof, rx_in.oof};
    accept = hsel && hready && htrans[1];
    wr = st_r.dp_wr;
    // Address phase capture; reads wait one cycle for flopped data
    st_nxt.dp_wr = accept && hwrite;
    st_nxt.rd_wait = accept && !hwrite;
    if (accept) begin
      st_nxt.idx = (haddr[31:10] == 22'h000000) ? haddr[9:2] : IDX_NONE;
    end
    // Data phase writes; unmapped indices are ignored
    if (wr) begin
      case (st_r.idx)
        IDX_SEC_CTL:  st_nxt.sec_ctl = hwdata[7:0] & SEC_CTL_MASK;
        IDX_TX_CTL:   st_nxt.tx_ctl = hwdata[7:0] & TX_CTL_MASK;
        IDX_TX_DIAG:  st_nxt.tx_diag = hwdata[7:0] & TX_DIAG_MASK;
        IDX_LINE_CTL: st_nxt.line_ctl = hwdata[7:0] & LINE_CTL_MASK;
        default:      st_nxt.line_ctl = st_r.line_ctl;
      endcase
    end
    poll = wr && (st_r.idx == IDX_CNT_LO || st_r.idx == IDX_CNT_HI ||
                  st_r.idx == IDX_PM_LOAD);
    st_nxt.perf_load = wr && (st_r.idx == IDX_PM_LOAD);
    // Read data; a status read clears the change flags
    rd_clr = st_r.rd_wait && (st_r.idx == IDX_SEC_STAT);
    if (st_r.rd_wait) begin
      case (st_r.idx)
        IDX_SEC_CTL:  st_nxt.rdata = st_r.sec_ctl;
        IDX_SEC_STAT: st_nxt.rdata = {1'b0, st_r.flags, alarms};
        IDX_CNT_LO:   st_nxt.rdata = st_r.cnt[7:0];
        IDX_CNT_HI:   st_nxt.rdata = st_r.cnt[15:8];
        IDX_TX_CTL:   st_nxt.rdata = st_r.tx_ctl;
        IDX_TX_DIAG:  st_nxt.rdata = st_r.tx_diag;
        IDX_LINE_CTL: st_nxt.rdata = {st_r.line_ctl[7:2],
                                      st_r.ais_st, st_r.rdi_st};
        default:      st_nxt.rdata = BYTE_ZERO;
      endcase
    end
    // Change and parity flags; a new event beats the read clear
    flag_set = {rx_in.b1_valid && (rx_in.b1_errs != 4'h0),
                alarms ^ st_r.prev};
    st_nxt.flags = (st_r.flags & ~(rd_clr ? FLAGS_ALL : 4'h0)) |
                   flag_set;
    st_nxt.prev = alarms;
    st_nxt.irq = |(st_r.flags[2:0] & st_r.sec_ctl[2:0]) ||
                 (st_r.flags[FL_PAR] && st_r.sec_ctl[SC_PAR_EN]);
    // B1 accumulation; the poll cycle's own errors join the copy
    b1_inc = 5'h00;
    if (rx_in.b1_valid) begin
      b1_inc = err_cnt({1'b0, rx_in.b1_errs}, st_r.sec_ctl[SC_B1_WORD]);
    end
    exp_sum = sat_add(st_r.acc, b1_inc);
    if (poll) begin
      st_nxt.cnt = exp_sum;
      st_nxt.acc = 16'h0000;
    end else begin
      st_nxt.acc = exp_sum;
    end
    // K2 persistence and per-frame line error events
    rdi_new = persist(st_r.rdi_cnt, rx_in.k2 == K2_RDI);
    ais_new = persist(st_r.ais_cnt, rx_in.k2 == K2_AIS);
    st_nxt.evt = '0;
    if (rx_in.frame_done) begin
      st_nxt.rdi_cnt = rdi_new;
      st_nxt.ais_cnt = ais_new;
      st_nxt.rdi_st = rdi_new >= (st_r.line_ctl[LC_RDI_SEL] ?
                                  PERSIST_FAST : PERSIST_SLOW);
      st_nxt.ais_st = ais_new >= (st_r.line_ctl[LC_AIS_SEL] ?
                                  PERSIST_FAST : PERSIST_SLOW);
      st_nxt.evt.b2_count = err_cnt(rx_in.b2_errs,
                                    st_r.line_ctl[LC_B2_WORD]);
      st_nxt.evt.b2_indicate = err_cnt(rx_in.b2_errs,
                                     st_r.line_ctl[LC_IND_WORD]);
      st_nxt.evt.febe_count = err_cnt(rx_in.m1_errs,
                                    st_r.line_ctl[LC_FEBE_WORD]);
    end
    // Downstream receive byte, forced to ones while AIS stands
    st_nxt.rx_out = (st_r.ais_st && st_r.line_ctl[LC_ONES]) ?
                    BYTE_ONES : rx_in.data;
    // Transmit: AIS only switches at a frame start
    ais_now = tx_in.frame_start ? st_r.tx_ctl[TC_LINE_ALARM_INSERT] : st_r.ais_act;
    st_nxt.ais_act = ais_now;
    scr_res = scr_step(st_r.scr);
    if (tx_in.frame_start) begin
      st_nxt.scr = SCR_SEED;
    end else if (!tx_in.row1) begin
      st_nxt.scr = scr_res[14:8];
    end
    txb = tx_in.data;
    if (ais_now && !tx_in.soh) begin
      txb = BYTE_ONES;
    end
    if (!st_r.tx_ctl[TC_BYPASS] && !tx_in.row1) begin
      txb = txb ^ scr_res[7:0];
    end
    if (tx_in.a1 && st_r.tx_diag[TD_A1]) begin
      txb = A1_ERR;
    end
    if (tx_in.b1 && st_r.tx_diag[TD_B1]) begin
      txb = ~txb;
    end
    if (st_r.tx_diag[TD_ZERO]) begin
      txb = BYTE_ZERO;
    end
    st_nxt.tx_out = txb;
  end

  // The whole state in one register
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_r <= ST_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  // Outputs straight from the state register
  assign hrdata      = {24'h000000, st_r.rdata};
  assign hreadyout   = !st_r.rd_wait;
  assign hresp       = 1'b0;
  assign rx_byte_out = st_r.rx_out;
  assign evt_out     = st_r.evt;
  assign alarm_irq   = st_r.irq;
  assign perf_load   = st_r.perf_load;
  assign tx_byte_out = st_r.tx_out;

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  sequence s_stat_read;
    st_r.rd_wait && st_r.idx == IDX_SEC_STAT;
  endsequence

  sequence s_poll;
    poll;
  endsequence

  property p_live_states;
    s_stat_read |=> hrdata[2:0] == $past(alarms) && hreadyout;
  endproperty
  a_live_states: assert property (p_live_states)
    else $error("status read lost live alarm states");

  property p_oof_flag;
    $changed(rx_in.oof) |=> st_r.flags[FL_OOF];
  endproperty
  a_oof_flag: assert property (p_oof_flag)
    else $error("frame state change not flagged");

  property p_flag_clear;
    s_stat_read ##0 !$changed(rx_in.los) |=> !st_r.flags[FL_LOS];
  endproperty
  a_flag_clear: assert property (p_flag_clear)
    else $error("status read did not clear flag");

  property p_par_flag;
    rx_in.b1_valid && rx_in.b1_errs != 4'h0 |=> st_r.flags[FL_PAR];
  endproperty
  a_par_flag: assert property (p_par_flag)
    else $error("parity error not flagged");

  property p_poll_restart;
    s_poll |-> ##[1:POLL_LIM] st_r.acc == 16'h0000;
  endproperty
  a_poll_restart: assert property (p_poll_restart)
    else $error("poll did not restart accumulation");

  property p_poll_keep;
    s_poll |=> st_r.cnt == $past(exp_sum);
  endproperty
  a_poll_keep: assert property (p_poll_keep)
    else $error("poll lost coincident error");

  property p_pm_load;
    wr && st_r.idx == IDX_PM_LOAD |=> perf_load && st_r.acc == 16'h0000;
  endproperty
  a_pm_load: assert property (p_pm_load)
    else $error("global load did not poll");

  property p_ais_edge;
    $changed(st_r.ais_act) |-> $past(tx_in.frame_start);
  endproperty
  a_ais_edge: assert property (p_ais_edge)
    else $error("AIS insertion changed mid-frame");

  property p_ais_ones;
    st_r.ais_act && !tx_in.frame_start && !tx_in.soh && !tx_in.b1 &&
    st_r.tx_ctl[TC_BYPASS] && st_r.tx_diag == 8'h00 |=>
      tx_byte_out == BYTE_ONES;
  endproperty
  a_ais_ones: assert property (p_ais_ones)
    else $error("AIS byte not all ones");

  property p_a1_err;
    tx_in.a1 && st_r.tx_diag[TD_A1] && !st_r.tx_diag[TD_ZERO] &&
    !tx_in.b1 |=> tx_byte_out == A1_ERR;
  endproperty
  a_a1_err: assert property (p_a1_err)
    else $error("A1 error not inserted");

  property p_zero_out;
    st_r.tx_diag[TD_ZERO] |=> tx_byte_out == BYTE_ZERO;
  endproperty
  a_zero_out: assert property (p_zero_out)
    else $error("forced loss output not zero");

  sequence s_rdi_fast;
    rx_in.frame_done && rx_in.k2 == K2_RDI &&
    st_r.line_ctl[LC_RDI_SEL] && st_r.rdi_cnt == 3'h2;
  endsequence

  property p_rdi_fast;
    s_rdi_fast |=> st_r.rdi_st;
  endproperty
  a_rdi_fast: assert property (p_rdi_fast)
    else $error("RDI not declared after three frames");

  property p_ais_slow;
    rx_in.frame_done && rx_in.k2 == K2_AIS &&
    !st_r.line_ctl[LC_AIS_SEL] && st_r.ais_cnt == 3'h3 |=> !st_r.ais_st;
  endproperty
  a_ais_slow: assert property (p_ais_slow)
    else $error("AIS declared before five frames");

  property p_ones_down;
    st_r.ais_st && st_r.line_ctl[LC_ONES] |=> rx_byte_out == BYTE_ONES;
  endproperty
  a_ones_down: assert property (p_ones_down)
    else $error("downstream not forced to ones");

  property p_febe_word;
    rx_in.frame_done && st_r.line_ctl[LC_FEBE_WORD] |=>
      evt_out.febe_count <= 5'h01;
  endproperty
  a_febe_word: assert property (p_febe_word)
    else $error("word mode FEBE count above one");

  property p_b2_modes;
    rx_in.frame_done && rx_in.b2_errs == 5'h03 &&
    st_r.line_ctl[LC_B2_WORD] && !st_r.line_ctl[LC_IND_WORD] |=>
      evt_out.b2_count == 5'h01 && evt_out.b2_indicate == 5'h03;
  endproperty
  a_b2_modes: assert property (p_b2_modes)
    else $error("B2 count and indication modes mixed");

  property p_b1_invert;
    tx_in.b1 && tx_in.soh && tx_in.row1 && !tx_in.a1 &&
    st_r.tx_diag[TD_B1] && !st_r.tx_diag[TD_ZERO] |=>
      tx_byte_out == ~$past(tx_in.data);
  endproperty
  a_b1_invert: assert property (p_b1_invert)
    else $error("B1 byte not inverted");

  property p_irq_los;
    st_r.flags[FL_LOS] && st_r.sec_ctl[FL_LOS] |=> alarm_irq;
  endproperty
  a_irq_los: assert property (p_irq_los)
    else $error("enabled signal loss change raised no interrupt");

  property p_line_read;
    st_r.rd_wait && st_r.idx == IDX_LINE_CTL |=>
      hrdata[1] == $past(st_r.ais_st) && hrdata[0] == $past(st_r.rdi_st);
  endproperty
  a_line_read: assert property (p_line_read)
    else $error("line status read lost live states");

endmodule

// [slom_line_model.sv]
`timescale 1ns/1ps
module slom_line_model
  import slom_pkg::*;
(
  // Clock and reset
  input  wire logic       hclk,
  input  wire logic       hresetn,
  // Transmit stream towards the block
  output slom_tx_in_t     tx_in,
  input  wire logic [7:0] tx_byte_out,
  // Last byte seen at each frame position
  output logic      [7:0] cap [8]
);
  logic [2:0] pos_r;
  logic [2:0] pos_d_r;

  // Eight byte frame: A1, B1, one more overhead byte, payload
  assign tx_in.data = (pos_r == 3'h0) ? 8'hF6 :
                      (pos_r == 3'h1) ? 8'h5A :
                      {5'h06, pos_r};
  assign tx_in.frame_start = (pos_r == 3'h0);
  assign tx_in.soh         = (pos_r < 3'h3);
  assign tx_in.row1        = (pos_r < 3'h2);
  assign tx_in.a1          = (pos_r == 3'h0);
  assign tx_in.b1          = (pos_r == 3'h1);

  // Line runs free; capture lags the byte by one edge of latency
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pos_r   <= 3'h0;
      pos_d_r <= 3'h0;
    end else begin
      pos_r        <= pos_r + 3'h1;
      pos_d_r      <= pos_r;
      cap[pos_d_r] <= tx_byte_out;
    end
  end
endmodule

// [slom_top_tb.sv]
`timescale 1ns/1ps
module slom_top_tb
  import slom_pkg::*;
;
  // Bus master and stimulus
  logic        hclk = 1'b0;
  logic        hresetn = 1'b0;
  logic        hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0]  htrans = 2'h0;
  logic        hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic        hreadyout;
  logic        hresp;
  logic [2:0]  al = 3'h0;
  logic        b1v = 1'b0;
  logic [3:0]  b1e = 4'h0;
  logic        fd = 1'b0;
  logic [2:0]  k2 = 3'h0;
  logic [4:0]  b2e = 5'h00;
  logic [4:0]  m1e = 5'h00;
  logic [7:0]  rxd = 8'h00;
  slom_rx_in_t rx_w;
  slom_tx_in_t tx_w;
  slom_evt_t   evt;
  logic [7:0]  rx_o;
  logic [7:0]  tx_o;
  logic        irq;
  logic        pl;
  logic [7:0]  cap [8];
  logic [31:0] v;
  logic [31:0] c1;
  logic [7:0]  md [4] = '{8'h00, 8'h80, 8'h08, 8'h04};
  logic [14:0] ev [4] = '{{5'h03, 5'h18, 5'h03}, {5'h01, 5'h18, 5'h03},
                          {5'h03, 5'h18, 5'h01}, {5'h03, 5'h01, 5'h03}};
  logic [7:0]  dpos [3] = '{8'h00, 8'h01, 8'h04};
  logic [7:0]  dval [3] = '{8'h76, 8'hA5, 8'h00};
  int          err_total = 0;
  int          check_count = 0;
  int          pl_seen = 0;

  always #20 hclk = ~hclk;
  assign rx_w = '{data: rxd, oof: al[0], lof: al[1], los: al[2],
                  b1_valid: b1v, b1_errs: b1e, frame_done: fd, k2: k2,
                  b2_errs: b2e, m1_errs: m1e};

  slom_top slom_top_i (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hready(hreadyout),
    .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .rx_in(rx_w), .rx_byte_out(rx_o), .evt_out(evt), .alarm_irq(irq),
    .perf_load(pl), .tx_in(tx_w), .tx_byte_out(tx_o));

  slom_line_model slom_line_model_i (
    .hclk(hclk), .hresetn(hresetn), .tx_in(tx_w), .tx_byte_out(tx_o),
    .cap(cap));

  // Count load pulses seen on the global strobe
  always @(posedge hclk) if (pl === 1'b1) pl_seen++;

  task automatic final_report();
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      err_total++;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Bounded wait for hready at a rising edge
  task automatic wait_rdy();
    int n;
    n = 0;
    @(posedge hclk);
    while (hreadyout !== 1'b1) begin
      n++;
      if (n > 20) begin
        err_total++;
        $display("ERROR at %0t: bus wait timed out", $time);
        final_report();
      end
      @(posedge hclk);
    end
  endtask

  // Write; pe pulses B1 errors during the data phase
  task automatic wr(input logic [7:0] idx, input logic [7:0] d,
                    input logic [3:0] pe);
    hsel   <= 1'b1;
    haddr  <= {22'h0, idx, 2'h0};
    htrans <= 2'h2;
    hwrite <= 1'b1;
    wait_rdy();
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= {24'h0, d};
    b1v    <= (pe != 4'h0);
    b1e    <= pe;
    wait_rdy();
    b1v    <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] idx);
    hsel   <= 1'b1;
    haddr  <= {22'h0, idx, 2'h0};
    htrans <= 2'h2;
    hwrite <= 1'b0;
    wait_rdy();
    hsel   <= 1'b0;
    htrans <= 2'h0;
    wait_rdy();
    v = hrdata;
  endtask

  // Snapshot count, both bytes
  task automatic rd_cnt();
    logic [31:0] lo;
    rd(IDX_CNT_LO);
    lo = v;
    rd(IDX_CNT_HI);
    v = (v << 8) | lo;
  endtask

  task automatic pb(input logic [3:0] e);
    b1v <= 1'b1;
    b1e <= e;
    @(posedge hclk);
    b1v <= 1'b0;
    repeat (2) @(posedge hclk);
  endtask

  // One frame end; evt_out is valid right after return
  task automatic fr(input logic [2:0] k, input logic [4:0] b2,
                    input logic [4:0] m1);
    fd  <= 1'b1;
    k2  <= k;
    b2e <= b2;
    m1e <= m1;
    @(posedge hclk);
    fd  <= 1'b0;
    @(posedge hclk);
  endtask

  // Watchdog against a hang anywhere
  initial begin
    repeat (20000) @(posedge hclk);
    err_total++;
    $display("ERROR at %0t: run timed out", $time);
    final_report();
  end

  initial begin
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rd(IDX_TX_CTL);
    chk(v, 32'h0);
    rd(IDX_LINE_CTL);
    chk(v, 32'h0);
    wr(IDX_TX_CTL, 8'h7F, 4'h0);
    rd(IDX_TX_CTL);
    chk(v, 32'h7F);
    wr(IDX_TX_DIAG, 8'hFF, 4'h0);
    rd(IDX_TX_DIAG);
    chk(v, 32'h07);
    wr(8'h30, 8'h5A, 4'h0);
    rd(8'h30);
    chk(v, 32'h0);
    chk(hresp, 32'h0);
    $display("test registers done");
    // Each alarm rising sets its flag; read clears it
    for (int i = 0; i < 3; i++) begin
      al[i] <= 1'b1;
      repeat (3) @(posedge hclk);
      rd(IDX_SEC_STAT);
      chk(v, (32'h8 << i) | ((32'h2 << i) - 32'h1));
      rd(IDX_SEC_STAT);
      chk(v, (32'h2 << i) - 32'h1);
    end
    al <= 3'h4;
    repeat (3) @(posedge hclk);
    chk(irq, 32'h0);
    rd(IDX_SEC_STAT);
    chk(v, 32'h1C);
    wr(IDX_SEC_CTL, 8'h04, 4'h0);
    al <= 3'h0;
    repeat (3) @(posedge hclk);
    chk(irq, 32'h1);
    rd(IDX_SEC_STAT);
    chk(v, 32'h20);
    repeat (2) @(posedge hclk);
    chk(irq, 32'h0);
    $display("test alarms done");
    // Error coincident with the poll must not be lost
    pb(4'h3);
    rd(IDX_SEC_STAT);
    chk(v, 32'h40);
    wr(IDX_CNT_HI, 8'h00, 4'h4);
    rd_cnt();
    c1 = v;
    chk(c1, 32'h7);
    chk(pl_seen, 32'h0);
    pb(4'h2);
    wr(IDX_PM_LOAD, 8'h00, 4'h0);
    rd_cnt();
    chk(c1 + v, 32'h9);
    chk(pl_seen, 32'h1);
    wr(IDX_SEC_CTL, 8'hFF, 4'h0);
    rd(IDX_SEC_CTL);
    chk(v, 32'h8F);
    // Block mode: one count per errored B1 byte
    pb(4'h5);
    chk(irq, 32'h1);
    wr(IDX_CNT_LO, 8'h00, 4'h3);
    rd_cnt();
    chk(v, 32'h2);
    chk(pl_seen, 32'h1);
    $display("test count done");
    // Slow RDI persistence, then fast AIS and forced ones
    repeat (4) fr(3'h6, 5'h00, 5'h00);
    rd(IDX_LINE_CTL);
    chk(v, 32'h0);
    fr(3'h6, 5'h00, 5'h00);
    rd(IDX_LINE_CTL);
    chk(v, 32'h1);
    wr(IDX_LINE_CTL, 8'h70, 4'h0);
    repeat (2) fr(3'h7, 5'h00, 5'h00);
    rd(IDX_LINE_CTL);
    chk(v, 32'h70);
    fr(3'h7, 5'h00, 5'h00);
    rxd <= 8'h3C;
    rd(IDX_LINE_CTL);
    chk(v, 32'h72);
    chk(rx_o, 32'hFF);
    fr(3'h0, 5'h00, 5'h00);
    repeat (2) @(posedge hclk);
    chk(rx_o, 32'h3C);
    // Fast RDI persistence, then slow AIS without forced ones
    repeat (2) fr(3'h6, 5'h00, 5'h00);
    rd(IDX_LINE_CTL);
    chk(v, 32'h70);
    fr(3'h6, 5'h00, 5'h00);
    rd(IDX_LINE_CTL);
    chk(v, 32'h71);
    wr(IDX_LINE_CTL, 8'h00, 4'h0);
    repeat (4) fr(3'h7, 5'h00, 5'h00);
    rd(IDX_LINE_CTL);
    chk(v, 32'h0);
    fr(3'h7, 5'h00, 5'h00);
    rd(IDX_LINE_CTL);
    chk(v, 32'h2);
    chk(rx_o, 32'h3C);
    $display("test line states done");
    // Count and indication modes, out of range FEBE clamps
    for (int i = 0; i < 4; i++) begin
      wr(IDX_LINE_CTL, md[i], 4'h0);
      fr(3'h0, 5'h03, 5'h1E);
      chk(evt, ev[i]);
    end
    $display("test events done");
    // Transmit path, one frame position at a time
    wr(IDX_TX_DIAG, 8'h00, 4'h0);
    wr(IDX_TX_CTL, 8'h40, 4'h0);
    repeat (24) @(posedge hclk);
    chk(cap[3], 32'h33);
    wr(IDX_TX_CTL, 8'h00, 4'h0);
    repeat (24) @(posedge hclk);
    // First scrambled byte after seed 7F carries FE
    chk(cap[2], 32'hCC);
    chk(cap[0], 32'hF6);
    wr(IDX_TX_CTL, 8'h41, 4'h0);
    repeat (24) @(posedge hclk);
    chk(cap[3], 32'hFF);
    chk(cap[2], 32'h32);
    wr(IDX_TX_CTL, 8'h40, 4'h0);
    for (int j = 0; j < 3; j++) begin
      wr(IDX_TX_DIAG, 8'h01 << j, 4'h0);
      repeat (24) @(posedge hclk);
      chk(cap[dpos[j]], dval[j]);
    end
    $display("test transmit done");
    final_report();
  end
endmodule
